// ---- core_exec_pkg.sv ----
// Shared constants, instruction encodings and carrier types for the execute unit
package core_exec_pkg;

  // Datapath widths
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int RAM_AW = 8;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;

  // Vector for a pending interrupt at interrupt exit
  localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h004;

  // Decimal fix-up constants
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;

  // Watchdog prescaler and counter terminal counts
  localparam logic [7:0] WD_PRESCALE_MAX = 8'hFF;
  localparam logic [7:0] WD_COUNT_MAX = 8'hFF;

  // Register offsets on the AXI4-Lite slave (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CORE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;

  // Field positions
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_WDRUN_BIT = 1;
  localparam int CORE_PC_LSB = 16;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operations handled by this unit
  typedef enum logic [4:0] {
    op_carry_sum_acc, op_carry_sum_into_ram, op_sum_acc, op_sum_imm, op_sum_into_ram,
    op_and_acc, op_and_imm, op_conjunction_into_ram, op_or_acc, op_or_imm,
    op_disjunction_into_ram, op_call, op_zero_fill, op_zero_bit, op_watchdog_clear,
    op_invert_in_ram, op_invert_into_acc, op_bcd_fixup, op_minus_one_in_ram,
    op_minus_one_into_acc, op_power_down, op_plus_one_in_ram, op_plus_one_into_acc,
    op_unconditional_branch, op_copy_ram_acc, op_copy_imm_acc, op_copy_acc_ram,
    op_idle_instruction, op_subroutine_exit, op_subroutine_exit_imm, op_interrupt_exit,
    op_rotate_left_byte
  } op_t;

  // One decoded instruction
  typedef struct packed {
    op_t op;
    logic [RAM_AW-1:0] addr;
    logic [7:0] imm;
    logic [2:0] bsel;
    logic [PC_W-1:0] target;
  } instr_t;

  // Status flags
  typedef struct packed {
    logic slept;
    logic expiry;
    logic sc;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } flags_t;

  // Execution phases
  typedef enum logic [1:0] {ph_fetch, ph_exec, ph_dummy, ph_sleep} phase_t;

endpackage

// ---- byte_store.sv ----
// Data memory: 256 bytes, one write port, registered read
`timescale 1ns/1ps
module byte_store
  import core_exec_pkg::*;
(
  input wire logic clk,
  input wire logic [RAM_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [RAM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);

  // Storage array, retained through power-down
  logic [7:0] cells [0:(1<<RAM_AW)-1];

  // Read first (a same-cycle write is not seen), read out through a register
  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end

endmodule

// ---- core_exec.sv ----
// Execute unit with data memory, stack, watchdog and register slave
//
// What this block does
// [RULE1] Carry sums add acc, byte, carry
// [RULE2] Plain sums add byte or immediate
// [RULE3] AND updates only zero flag
// [RULE4] OR updates only zero flag
// [RULE5] Call pushes pc plus one, two cycles
// [RULE6] Byte or bit clear, no flags
// [RULE7] Watchdog clear resets count and flags
// [RULE8] Complement byte, only zero flag
// [RULE9] Decimal fix-up into memory, carry only
// [RULE10] Decrement byte, only zero flag
// [RULE11] Increment byte, only zero flag
// [RULE12] Power-down stops, sets sleep flag
// [RULE13] Branch loads address, two cycles
// [RULE14] Copies move data, no flags
// [RULE15] Idle changes nothing but the pc
// [RULE16] Exit pops pc, optional acc load
// [RULE17] Interrupt exit re-enables, serves pending
// [RULE18] Rotate left, bit7 to bit0
// [RULE19] Single cycle unless stated, exits take two; eight bits
// [RULE20] Zero flag set when result zero
`timescale 1ns/1ps
module core_exec
  import core_exec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire instr_t instr_in,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic irq_pending,
  input wire logic wake,
  output logic [PC_W-1:0] pc,
  output logic [7:0] acc,
  output flags_t flags,
  output logic global_irq_enable,
  output logic clk_gate_off,
  output logic irq_taken,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Whole module state
  typedef struct packed {
    phase_t phase;
    instr_t ins;
    logic [7:0] acc;
    flags_t flg;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic gie;
    logic wd_run;
    logic [7:0] prescale;
    logic [7:0] wdt;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st; // Registered state
  state_t next_st; // Next state

  // Memory ports
  logic [RAM_AW-1:0] mem_ra; // Read address
  logic [7:0] mem_rd; // Read data, valid in exec phase
  logic mem_we; // Write strobe
  logic [7:0] mem_wd; // Write data

  // Arithmetic temporaries
  logic [7:0] opnd; // Second operand
  logic cin; // Carry into the adder
  logic [4:0] lo5; // Low nibble sum
  logic [8:0] s9; // Full sum with carry out
  logic [7:0] res; // Eight bit result
  logic [8:0] bcd9; // Decimal fix-up sum
  logic [SP_W-1:0] pop_idx; // Top of stack
  logic aw_fire; // Write address and data taken
  logic wd_wrap; // Watchdog overflow this cycle

  // Read address from the offered word while idle
  assign mem_ra = (st.phase == ph_fetch) ? instr_in.addr : st.ins.addr;

  byte_store u_store (
    .clk(clk),
    .rd_addr(mem_ra),
    .rd_data(mem_rd),
    .wr_en(mem_we),
    .wr_addr(st.ins.addr),
    .wr_data(mem_wd)
  );

  // Combinational handshakes; write needs both channels
  assign instr_ready = (st.phase == ph_fetch);
  assign aw_fire = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
  assign s_axi_awready = aw_fire;
  assign s_axi_wready = aw_fire;
  assign s_axi_arready = !st.rvalid;

  // Outputs from state
  assign pc = st.pc;
  assign acc = st.acc;
  assign flags = st.flg;
  assign global_irq_enable = st.gie;
  assign clk_gate_off = (st.phase == ph_sleep);
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

  // Next-state logic: execution, watchdog and bus slave
  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_wd = 8'h00;
    irq_taken = 1'b0;
    wd_wrap = 1'b0;
    pop_idx = 3'(st.sp - 3'h1);
    // Immediate forms use the instruction byte
    if (st.ins.op inside {op_sum_imm, op_and_imm, op_or_imm}) begin
      opnd = st.ins.imm;
    end else begin
      opnd = mem_rd;
    end
    cin = (st.ins.op inside {op_carry_sum_acc, op_carry_sum_into_ram}) ? st.flg.c : 1'b0;
    // [RULE19] eight bit truncation
    lo5 = 5'({1'b0, st.acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin});
    s9 = 9'({1'b0, st.acc} + {1'b0, opnd} + {8'h00, cin});
    res = s9[7:0];
    // [RULE9] decimal adjust of the accumulator
    bcd9 = {1'b0, st.acc};
    if (st.acc[3:0] > BCD_LIMIT || st.flg.ac) begin
      bcd9 = 9'(bcd9 + {5'h00, BCD_ADJ});
    end
    if (st.acc[7:4] > BCD_LIMIT || st.flg.c) begin
      bcd9 = 9'(bcd9 + {1'b0, BCD_ADJ, 4'h0});
    end

    case (st.phase)
      // Take a word; memory read starts now
      ph_fetch: begin
        if (instr_valid) begin
          next_st.ins = instr_in;
          next_st.phase = ph_exec;
        end
      end
      // One instruction cycle of work
      ph_exec: begin
        // [RULE19] default single cycle, step pc
        next_st.phase = ph_fetch;
        next_st.pc = 12'(st.pc + 12'h001);
        case (st.ins.op)
          // [RULE1] [RULE2] sums set five arithmetic flags
          op_carry_sum_acc, op_sum_acc, op_sum_imm, op_carry_sum_into_ram,
          op_sum_into_ram: begin
            next_st.flg.c = s9[8];
            next_st.flg.ac = lo5[4];
            next_st.flg.ov = (st.acc[7] == opnd[7]) && (res[7] != st.acc[7]);
            next_st.flg.sc = res[7] ^ ((st.acc[7] == opnd[7]) && (res[7] != st.acc[7]));
            // [RULE20] zero flag from result
            next_st.flg.z = (res == 8'h00);
            if (st.ins.op inside {op_carry_sum_into_ram, op_sum_into_ram}) begin
              mem_we = 1'b1;
              mem_wd = res;
            end else begin
              next_st.acc = res;
            end
          end
          // [RULE3] conjunction, zero flag only
          op_and_acc, op_and_imm, op_conjunction_into_ram: begin
            next_st.flg.z = ((st.acc & opnd) == 8'h00);
            if (st.ins.op == op_conjunction_into_ram) begin
              mem_we = 1'b1;
              mem_wd = st.acc & opnd;
            end else begin
              next_st.acc = st.acc & opnd;
            end
          end
          // [RULE4] disjunction, zero flag only
          op_or_acc, op_or_imm, op_disjunction_into_ram: begin
            next_st.flg.z = ((st.acc | opnd) == 8'h00);
            if (st.ins.op == op_disjunction_into_ram) begin
              mem_we = 1'b1;
              mem_wd = st.acc | opnd;
            end else begin
              next_st.acc = st.acc | opnd;
            end
          end
          // [RULE5] push return, load target
          op_call: begin
            next_st.stack[st.sp] = 12'(st.pc + 12'h001);
            next_st.sp = 3'(st.sp + 3'h1);
            next_st.pc = st.ins.target;
            next_st.phase = ph_dummy;
          end
          // [RULE6] clears write memory only
          op_zero_fill: begin
            mem_we = 1'b1;
            mem_wd = 8'h00;
          end
          op_zero_bit: begin
            mem_we = 1'b1;
            mem_wd = mem_rd & ~(8'h01 << st.ins.bsel);
          end
          // [RULE7] watchdog clear
          op_watchdog_clear: begin
            next_st.wdt = 8'h00;
            next_st.prescale = 8'h00;
            next_st.flg.expiry = 1'b0;
            next_st.flg.slept = 1'b0;
          end
          // [RULE8] ones complement
          op_invert_in_ram, op_invert_into_acc: begin
            next_st.flg.z = (~mem_rd == 8'h00);
            if (st.ins.op == op_invert_in_ram) begin
              mem_we = 1'b1;
              mem_wd = ~mem_rd;
            end else begin
              next_st.acc = ~mem_rd;
            end
          end
          // [RULE9] result to memory, carry may only rise
          op_bcd_fixup: begin
            mem_we = 1'b1;
            mem_wd = bcd9[7:0];
            next_st.flg.c = st.flg.c | bcd9[8];
          end
          // [RULE10] decrement
          op_minus_one_in_ram, op_minus_one_into_acc: begin
            next_st.flg.z = (8'(mem_rd - 8'h01) == 8'h00);
            if (st.ins.op == op_minus_one_in_ram) begin
              mem_we = 1'b1;
              mem_wd = 8'(mem_rd - 8'h01);
            end else begin
              next_st.acc = 8'(mem_rd - 8'h01);
            end
          end
          // [RULE11] increment
          op_plus_one_in_ram, op_plus_one_into_acc: begin
            next_st.flg.z = (8'(mem_rd + 8'h01) == 8'h00);
            if (st.ins.op == op_plus_one_in_ram) begin
              mem_we = 1'b1;
              mem_wd = 8'(mem_rd + 8'h01);
            end else begin
              next_st.acc = 8'(mem_rd + 8'h01);
            end
          end
          // [RULE12] power-down; state is kept, watchdog restarts
          op_power_down: begin
            next_st.wdt = 8'h00;
            next_st.prescale = 8'h00;
            next_st.flg.slept = 1'b1;
            next_st.flg.expiry = 1'b0;
            next_st.phase = ph_sleep;
          end
          // [RULE13] branch with dummy cycle
          op_unconditional_branch: begin
            next_st.pc = st.ins.target;
            next_st.phase = ph_dummy;
          end
          // [RULE14] copies leave flags alone
          op_copy_ram_acc: next_st.acc = mem_rd;
          op_copy_imm_acc: next_st.acc = st.ins.imm;
          op_copy_acc_ram: begin
            mem_we = 1'b1;
            mem_wd = st.acc;
          end
          // [RULE16] pop, optionally load accumulator
          op_subroutine_exit, op_subroutine_exit_imm: begin
            next_st.pc = st.stack[pop_idx];
            next_st.sp = pop_idx;
            next_st.phase = ph_dummy;
            if (st.ins.op == op_subroutine_exit_imm) begin
              next_st.acc = st.ins.imm;
            end
          end
          // [RULE17] pop and enable; a pending request is served first
          op_interrupt_exit: begin
            next_st.phase = ph_dummy;
            if (irq_pending) begin
              // Return address stays stacked, so the handler returns to it
              next_st.pc = IRQ_VECTOR;
              next_st.gie = 1'b0;
              irq_taken = 1'b1;
            end else begin
              next_st.pc = st.stack[pop_idx];
              next_st.sp = pop_idx;
              next_st.gie = 1'b1;
            end
          end
          // [RULE18] rotate left, flags untouched
          op_rotate_left_byte: begin
            mem_we = 1'b1;
            mem_wd = {mem_rd[6:0], mem_rd[7]};
          end
          // [RULE15] idle: only pc moves on
          default: begin
          end
        endcase
      end
      // Filler cycle while a new address loads
      ph_dummy: next_st.phase = ph_fetch;
      // System clock is gated off until woken
      ph_sleep: begin
        if (wake) begin
          next_st.phase = ph_fetch;
        end
      end
      default: next_st.phase = ph_fetch;
    endcase

    // Watchdog; overflow sets the flag even if cleared in the same cycle
    if (st.wd_run) begin
      next_st.prescale = 8'(next_st.prescale + 8'h01);
      if (st.prescale == WD_PRESCALE_MAX) begin
        wd_wrap = (st.wdt == WD_COUNT_MAX);
        next_st.wdt = 8'(next_st.wdt + 8'h01);
      end
    end
    if (wd_wrap) begin
      next_st.flg.expiry = 1'b1;
    end

    // Write channel: response held until bready
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (aw_fire) begin
      next_st.bvalid = 1'b1;
      if (s_axi_awaddr[7:0] == OFS_CTRL) begin
        next_st.bresp = RESP_OKAY;
        if (s_axi_wstrb[0]) begin
          next_st.gie = s_axi_wdata[CTRL_GIE_BIT];
          next_st.wd_run = s_axi_wdata[CTRL_WDRUN_BIT];
        end
      end else if (s_axi_awaddr[7:0] == OFS_STATUS || s_axi_awaddr[7:0] == OFS_CORE) begin
        // Read-only words ignore writes
        next_st.bresp = RESP_OKAY;
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end

    // Read channel: data registered, held until rready
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      if (s_axi_araddr[7:0] == OFS_STATUS) begin
        next_st.rdata = {25'h0, st.flg};
      end else if (s_axi_araddr[7:0] == OFS_CORE) begin
        next_st.rdata = {4'h0, st.pc, 8'h00, st.acc};
      end else if (s_axi_araddr[7:0] == OFS_CTRL) begin
        next_st.rdata = {30'h0, st.wd_run, st.gie};
      end else begin
        next_st.rdata = 32'h0;
        next_st.rresp = RESP_SLVERR;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.phase <= ph_fetch;
      st.acc <= ACC_RESET;
      st.pc <= PC_RESET;
      st.sp <= SP_RESET;
      st.ins.op <= op_idle_instruction;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Execution of a given operation
  logic in_exec;
  assign in_exec = (st.phase == ph_exec);

  sequence s_dummy_then_fetch;
    (st.phase == ph_dummy) ##1 (st.phase == ph_fetch);
  endsequence

  a_call_push_load: assert property ( // RULE5
    in_exec && st.ins.op == op_call |=> (st.pc == $past(st.ins.target))
      && (st.stack[$past(st.sp)] == 12'($past(st.pc) + 12'h001)) ##0 s_dummy_then_fetch)
    else $error("call wrong");

  a_branch_two_cycle: assert property ( // RULE13
    in_exec && st.ins.op == op_unconditional_branch
      |=> (st.pc == $past(st.ins.target)) ##0 s_dummy_then_fetch)
    else $error("branch wrong");

  a_single_cycle_step: assert property ( // RULE19
    in_exec && st.ins.op inside {op_sum_acc, op_and_acc, op_copy_ram_acc, op_idle_instruction}
      |=> st.phase == ph_fetch && st.pc == 12'($past(st.pc) + 12'h001))
    else $error("pc not stepped");

  a_carry_sum_value: assert property ( // RULE1
    in_exec && st.ins.op == op_carry_sum_acc
      |=> st.acc == 8'($past(st.acc) + $past(mem_rd) + {7'h0, $past(st.flg.c)}))
    else $error("carry sum wrong");

  a_zero_flag_and: assert property ( // RULE20
    in_exec && st.ins.op inside {op_and_acc, op_and_imm} |=> st.flg.z == (st.acc == 8'h00))
    else $error("zero flag wrong");

  a_zero_fill_write: assert property ( // RULE6
    in_exec && st.ins.op == op_zero_fill |-> mem_we && mem_wd == 8'h00 ##1 $stable(st.flg))
    else $error("zero fill wrong");

  a_rotate_left: assert property ( // RULE18
    in_exec && st.ins.op == op_rotate_left_byte
      |-> mem_we && mem_wd == {mem_rd[6:0], mem_rd[7]})
    else $error("rotate left wrong");

  a_sleep_entry: assert property ( // RULE12
    in_exec && st.ins.op == op_power_down |=> clk_gate_off && st.flg.slept && st.wdt == 8'h00)
    else $error("power-down entry wrong");

  a_watchdog_clear: assert property ( // RULE7
    in_exec && st.ins.op == op_watchdog_clear |=> !st.flg.slept && st.wdt <= 8'h01)
    else $error("watchdog clear wrong");

  a_irq_exit_enable: assert property ( // RULE17
    in_exec && st.ins.op == op_interrupt_exit && !irq_pending && !aw_fire
      |=> st.gie ##1 st.phase == ph_fetch)
    else $error("interrupt exit did not enable");

  a_idle_no_change: assert property ( // RULE15
    in_exec && st.ins.op == op_idle_instruction |-> !mem_we ##1 $stable(st.acc))
    else $error("idle changed state");

endmodule

// ---- instr_source.sv ----
// Instruction source model standing in for program memory
`timescale 1ns/1ps
module instr_source
  import core_exec_pkg::*;
(
  input wire logic clk,
  input wire logic instr_ready,
  output instr_t instr_in,
  output logic instr_valid
);
  // Offer a word until taken, then count busy cycles
  task automatic issue(input instr_t ins, output int busy, output bit ok);
    int n;
    busy = 0;
    ok = 0;
    instr_in <= ins;
    instr_valid <= 1'b1;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = instr_ready;
    end
    instr_valid <= 1'b0;
    // Scramble so a stale read cannot pass
    instr_in <= instr_t'(~ins);
    ok = 0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      ok = instr_ready;
      if (!ok) busy++;
    end
  endtask

  initial begin
    instr_valid = 1'b0;
    instr_in = '0;
  end
endmodule

// ---- core_exec_test.sv ----
// Self-checking bench for the execute unit
`timescale 1ns/1ps
module core_exec_test
  import core_exec_pkg::*;
  ;
  logic clk, rst, instr_valid, instr_ready, irq_pending, wake;
  instr_t instr_in;
  logic [PC_W-1:0] pc;
  logic [7:0] acc;
  flags_t flags;
  logic global_irq_enable, clk_gate_off, irq_taken;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors = 0, total_checks = 0, irq_seen = 0;
  logic [31:0] seed = 32'h1800E;
  // Reference model
  logic [7:0] m_acc, ram [8];
  logic [PC_W-1:0] m_pc, stk [8];
  logic [2:0] sp;
  logic m_gie;
  flags_t m_fl;
  op_t o;

  core_exec i_core_exec (.clk, .rst, .instr_in, .instr_valid, .instr_ready, .irq_pending,
    .wake, .pc, .acc, .flags, .global_irq_enable, .clk_gate_off, .irq_taken, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  instr_source i_instr_source (.clk, .instr_ready, .instr_in, .instr_valid);

  always #5 clk = ~clk;
  // Count interrupt-taken pulses
  always @(posedge clk) if (irq_taken === 1'b1) irq_seen++;

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    finish_test();
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic instr_t mk(op_t o, logic [7:0] a = 8'h00, logic [7:0] x = 8'h00);
    return '{o, a, x, 3'(rnd()), 12'(rnd())};
  endfunction

  // Ops that take a dummy cycle
  function automatic bit two_cyc(op_t p);
    return p inside {op_call, op_unconditional_branch, op_subroutine_exit,
      op_subroutine_exit_imm, op_interrupt_exit};
  endfunction

  // Expected effect of one op
  function automatic void model(instr_t i);
    logic [7:0] m, x, r;
    logic [8:0] s;
    logic [1:0] dst;
    m = ram[i.addr[2:0]];
    x = (i.op inside {op_sum_imm, op_and_imm, op_or_imm}) ? i.imm : m;
    r = m;
    s = 9'h000;
    dst = (i.op inside {op_carry_sum_into_ram, op_sum_into_ram, op_conjunction_into_ram,
      op_disjunction_into_ram, op_zero_fill, op_zero_bit, op_invert_in_ram, op_bcd_fixup,
      op_minus_one_in_ram, op_plus_one_in_ram, op_copy_acc_ram, op_rotate_left_byte}) ? 2'h2
      : (two_cyc(i.op) || i.op inside {op_watchdog_clear, op_power_down, op_idle_instruction})
      ? 2'h0 : 2'h1;
    m_pc = m_pc + 12'h001;
    case (i.op)
      op_carry_sum_acc, op_carry_sum_into_ram, op_sum_acc, op_sum_imm, op_sum_into_ram: begin
        s[0] = (i.op inside {op_carry_sum_acc, op_carry_sum_into_ram}) && m_fl.c;
        m_fl.ac = ({1'b0, m_acc[3:0]} + x[3:0] + s[0]) > 5'h0F;
        s = m_acc + x + s[0];
        r = s[7:0];
        m_fl.c = s[8];
        m_fl.ov = (m_acc[7] == x[7]) && (r[7] != x[7]);
        m_fl.sc = r[7] ^ m_fl.ov;
      end
      op_and_acc, op_and_imm, op_conjunction_into_ram: r = m_acc & x;
      op_or_acc, op_or_imm, op_disjunction_into_ram: r = m_acc | x;
      op_zero_fill: r = 8'h00;
      op_zero_bit: r = m & ~(8'h01 << i.bsel);
      op_invert_in_ram, op_invert_into_acc: r = ~m;
      op_minus_one_in_ram, op_minus_one_into_acc: r = m - 8'h01;
      op_plus_one_in_ram, op_plus_one_into_acc: r = m + 8'h01;
      op_copy_imm_acc: r = i.imm;
      op_copy_acc_ram: r = m_acc;
      op_rotate_left_byte: r = {m[6:0], m[7]};
      op_bcd_fixup: begin
        s = {1'b0, m_acc} + {1'b0, (m_acc[7:4] > BCD_LIMIT || m_fl.c) ? BCD_ADJ : 4'h0,
          (m_acc[3:0] > BCD_LIMIT || m_fl.ac) ? BCD_ADJ : 4'h0};
        r = s[7:0];
        m_fl.c = m_fl.c | s[8];
      end
      op_watchdog_clear, op_power_down: begin
        m_fl.expiry = 1'b0;
        m_fl.slept = (i.op == op_power_down);
      end
      op_call: begin
        stk[sp] = m_pc;
        sp++;
        m_pc = i.target;
      end
      op_unconditional_branch: m_pc = i.target;
      op_subroutine_exit, op_subroutine_exit_imm, op_interrupt_exit: begin
        if (i.op == op_interrupt_exit && irq_pending) m_pc = IRQ_VECTOR;
        else begin
          sp--;
          m_pc = stk[sp];
          m_gie = m_gie | (i.op == op_interrupt_exit);
        end
        if (i.op == op_subroutine_exit_imm) m_acc = i.imm;
      end
      default: ;
    endcase
    if (dst == 2'h1) m_acc = r;
    if (dst == 2'h2) ram[i.addr[2:0]] = r;
    if (dst != 2'h0 && !(i.op inside {op_zero_fill, op_zero_bit, op_bcd_fixup,
      op_copy_ram_acc, op_copy_imm_acc, op_copy_acc_ram, op_rotate_left_byte}))
      m_fl.z = (r == 8'h00);
  endfunction

  // Issue one op, compare results
  task automatic run(instr_t i);
    int busy;
    bit ok;
    model(i);
    i_instr_source.issue(i, busy, ok);
    if (!ok) hang();
    if (i.op != op_power_down) check(busy, two_cyc(i.op) ? 2 : 1);
    check(acc, m_acc);
    check(flags, m_fl);
    check(pc, m_pc);
    check(global_irq_enable, m_gie);
  endtask

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] exp);
    int n;
    bit aw = 1, w = 1;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 20 && (aw || w); n++) begin
      @(posedge clk);
      if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
    end
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20 && !s_axi_bvalid; n++) @(posedge clk);
    if (aw || w || !s_axi_bvalid) hang();
    check(s_axi_bresp, exp);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(logic [7:0] a, logic [31:0] d, logic [1:0] exp);
    int n;
    bit ar = 1;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 20 && ar; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      ar = !s_axi_arready;
    end
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20 && !s_axi_rvalid; n++) @(posedge clk);
    if (ar || !s_axi_rvalid) hang();
    check(s_axi_rdata, d);
    check(s_axi_rresp, exp);
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    #500000;
    hang();
  end

  initial begin
    clk = 0;
    rst = 1;
    irq_pending = 0;
    wake = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    {m_acc, m_pc, sp, m_gie, m_fl} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Memory is not reset, so fill the bytes in use first
    for (int k = 0; k < 8; k++) begin
      run(mk(op_copy_imm_acc, 8'h00, 8'(rnd())));
      run(mk(op_copy_acc_ram, 8'(k)));
    end
    // Corners: overflow to zero, fix-up with both carries
    run(mk(op_copy_imm_acc, 8'h00, 8'h80));
    run(mk(op_sum_imm, 8'h00, 8'h80));
    run(mk(op_carry_sum_acc));
    run(mk(op_copy_imm_acc, 8'h00, 8'h99));
    run(mk(op_sum_imm, 8'h00, 8'h99));
    run(mk(op_bcd_fixup, 8'h01));
    for (int k = 0; k < 150; k++) begin
      o = op_t'(5'(rnd()));
      // Stack and sleep ops are driven by hand below
      if (!two_cyc(o) && o != op_power_down) run(mk(o, 8'(rnd() & 7), 8'(rnd())));
    end
    run(mk(op_call));
    run(mk(op_call));
    run(mk(op_subroutine_exit_imm, 8'h00, 8'h5A));
    run(mk(op_subroutine_exit));
    run(mk(op_unconditional_branch));
    // exit with a request pending, then without
    run(mk(op_call));
    irq_pending <= 1'b1;
    @(posedge clk);
    run(mk(op_interrupt_exit));
    irq_pending <= 1'b0;
    @(posedge clk);
    run(mk(op_interrupt_exit));
    check(irq_seen, 1);
    // power-down until wake, then watchdog clear
    fork
      run(mk(op_power_down));
      begin
        repeat (5) @(posedge clk);
        check(clk_gate_off, 1'b1);
        check(flags.slept, 1'b1);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
      end
    join
    run(mk(op_watchdog_clear));
    // Register slave: status, core view, control, unmapped
    axi_rd(OFS_STATUS, {25'h0, m_fl}, RESP_OKAY);
    axi_rd(OFS_CORE, {4'h0, m_pc, 8'h00, m_acc}, RESP_OKAY);
    axi_wr(OFS_STATUS, 32'h0000007F, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h00000000, RESP_OKAY);
    m_gie = 1'b0;
    axi_rd(OFS_CTRL, 32'h00000000, RESP_OKAY);
    axi_rd(8'h0C, 32'h00000000, RESP_SLVERR);
    axi_wr(8'h0C, 32'h00000001, RESP_SLVERR);
    run(mk(op_idle_instruction));
    // Read bytes back via acc
    for (int k = 0; k < 8; k++) run(mk(op_copy_ram_acc, 8'(k)));
    finish_test();
  end
endmodule
